// ---- usb_epbuf_defs.vh ----
// Purpose: shared constants for the endpoint buffer manager
// Assumes: included by bare name from every design file
// Notes:   byte addresses on the wishbone port, all word aligned
`ifndef USB_EPBUF_DEFS_VH
`define USB_EPBUF_DEFS_VH

// register byte addresses
`define A_EP_SEL      8'h00
`define A_EP_CTRL     8'h04
`define A_BUF_OFF     8'h08
`define A_BUF_DATA    8'h0c
`define A_EP_LEN      8'h10
`define A_MAX_LEN     8'h14
`define A_IRQ_STAT    8'h18
`define A_IRQ_CLR     8'h1c
`define A_IRQ_EN      8'h20

// endpoint_buffer_control_reg fields
`define CF_DUAL       0
`define CF_PAGE       1
`define CF_DIR        2
`define CF_INC        3
`define CF_SOF_CMPL   4
`define CF_DONE       5
`define CF_TYPE_LO    6
`define CF_TYPE_HI    7
`define CF_CBF        8
`define CF_UBF        9
`define CF_OK         10

// transfer types
`define T_CTRL        2'h0
`define T_ISO         2'h1
`define T_BULK        2'h2
`define T_INT         2'h3

// lengths and sizes
`define CTRL_DEF_LEN  7'h08
`define PKT_MAX_LEN   7'h40
`define EP1_DEF_LEN   7'h40
`define CFG_RESET     8'h00
`define OFF_W         7
`define RAM_AW        8
`define RAM_DEPTH     256

`endif

// ---- usb_packet_ram.v ----
// Purpose: two pages of packet memory, one port for the cpu, one for usb
// Assumes: address is {page, endpoint, byte offset}
// Notes:   combinational read; on a same-address write clash usb wins
`include "usb_epbuf_defs.vh"
`timescale 1ns/1ps
module usb_packet_ram (
	input  wire                clk_sys, // system clock
	input  wire                a_we,    // cpu write strobe
	input  wire [`RAM_AW-1:0]  a_addr,  // cpu address
	input  wire [7:0]          a_wdata, // cpu write byte
	output wire [7:0]          a_rdata, // cpu read byte
	input  wire                b_we,    // usb write strobe
	input  wire [`RAM_AW-1:0]  b_addr,  // usb address
	input  wire [7:0]          b_wdata, // usb write byte
	output wire [7:0]          b_rdata  // usb read byte
);
	reg [7:0] mem [0:`RAM_DEPTH-1];

	assign a_rdata = mem[a_addr];
	assign b_rdata = mem[b_addr];

	always @(posedge clk_sys) begin
		if (a_we)
			mem[a_addr] <= a_wdata;
		if (b_we)
			mem[b_addr] <= b_wdata;
	end
endmodule // usb_packet_ram

// ---- ep_buffer_ctrl.v ----
// Purpose: buffer ownership, offsets and lengths for one endpoint
// Assumes: all strobes are one-cycle pulses on clk_sys
// Notes:   ubf = usb-side buffer full, cbf = cpu-side buffer full
`include "usb_epbuf_defs.vh"
`timescale 1ns/1ps
module ep_buffer_ctrl (
	input  wire              clk_sys,   // system clock
	input  wire              reset_n,   // sync reset, active low
	input  wire              dual_en,   // dual buffer mode
	input  wire              page_sel,  // page used in single mode
	input  wire              dir_in,    // device-to-host pipe
	input  wire              inc_en,    // offset_autoincrement_enable
	input  wire              sof_cmpl_en, // frame_start_completes_enable
	input  wire [`OFF_W-1:0] max_len,   // max_packet_length
	input  wire              off_wr,    // buffer_offset_reg write
	input  wire [`OFF_W-1:0] off_wdata, // new offset
	input  wire              cpu_rd,    // buffer_data_reg read
	input  wire              cpu_wr,    // buffer_data_reg write
	input  wire              cpu_done,  // done bit written
	input  wire              usb_byte,  // usb moved one byte
	input  wire              usb_ok,    // usb packet ended correctly
	input  wire              usb_bad,   // usb packet aborted
	input  wire              sof,       // start of frame
	output reg [`OFF_W-1:0]  coff_r,    // cpu-side offset
	output reg [`OFF_W-1:0]  ucnt_r,    // usb byte counter
	output reg [`OFF_W-1:0]  clen_r,    // endpoint_length_reg
	output reg [`OFF_W-1:0]  ulen_r,    // length of usb-side buffer
	output reg               cbf_r,     // cpu-side buffer full
	output reg               ubf_r,     // usb-side buffer full
	output wire              cpu_page,  // page the cpu sees
	output wire              usb_page,  // page usb sees
	output wire              usb_ready, // usb may move data
	output wire              cpu_avail, // cpu may access data
	output wire              usb_cmpl,  // usb_side_complete_flag event
	output wire              cpu_cmpl   // cpu_side_complete_flag event
);
	reg              page_r;
	reg              cbf_nxt;
	reg              ubf_nxt;
	wire [`OFF_W-1:0] off_inc = coff_r + 7'h01;
	wire              acc     = dir_in ? cpu_wr : cpu_rd;
	wire              seq_last;
	wire              swap;
	wire [`OFF_W-1:0] clen_nxt;
	wire [`OFF_W-1:0] ulen_nxt;

	// in single mode both sides share one page, so each side waits on the other
	assign cpu_page  = dual_en ? page_r : page_sel; // R8 R9
	assign usb_page  = dual_en ? ~page_r : page_sel; // R8 R9
	assign cpu_avail = dir_in ? (!cbf_r && (dual_en || !ubf_r)) : cbf_r;
	assign usb_ready = dir_in ? ubf_r : (!ubf_r && (dual_en || !cbf_r));
	assign seq_last  = inc_en & acc &
		(dir_in ? (off_inc == max_len) : (off_inc >= clen_r)); // R13 R16 R17
	assign cpu_cmpl = cpu_avail & (seq_last | cpu_done | (dir_in & sof_cmpl_en & sof)); // R10 R18
	assign usb_cmpl = usb_ok & usb_ready; // R15

	always @* begin
		cbf_nxt = cbf_r;
		ubf_nxt = ubf_r;
		if (dir_in) begin
			if (cpu_cmpl)
				cbf_nxt = 1'b1;
			if (usb_cmpl)
				ubf_nxt = 1'b0;
		end else begin
			if (usb_cmpl)
				ubf_nxt = 1'b1;
			if (cpu_cmpl)
				cbf_nxt = 1'b0;
		end
	end

	// hand a full buffer to the consumer as soon as its own buffer is empty
	assign swap = dir_in ? (cbf_nxt & !ubf_nxt) : (ubf_nxt & !cbf_nxt); // R9
	assign clen_nxt = (dir_in & cpu_cmpl) ? (seq_last ? off_inc : coff_r) : clen_r;
	assign ulen_nxt = (!dir_in & usb_cmpl) ? ucnt_r : ulen_r; // R15

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			coff_r <= 7'h00; // R19
			ucnt_r <= 7'h00;
			clen_r <= 7'h00;
			ulen_r <= 7'h00;
			cbf_r  <= 1'b0; // R19
			ubf_r  <= 1'b0;
			page_r <= 1'b0;
		end else begin
			if (swap) begin
				cbf_r <= !dir_in;
				ubf_r <= dir_in;
				if (dual_en)
					page_r <= ~page_r; // R9
			end else begin
				cbf_r <= cbf_nxt;
				ubf_r <= ubf_nxt;
			end
			clen_r <= (swap & !dir_in) ? ulen_nxt : clen_nxt; // R15
			ulen_r <= (swap & dir_in) ? clen_nxt : ulen_nxt;
			if (cpu_cmpl)
				coff_r <= 7'h00;
			else if (off_wr)
				coff_r <= off_wdata; // R11
			else if (acc & cpu_avail & inc_en)
				coff_r <= off_inc; // R12
			if (usb_ok | usb_bad)
				ucnt_r <= 7'h00;
			else if (usb_byte & usb_ready)
				ucnt_r <= ucnt_r + 7'h01;
		end
	end
endmodule // ep_buffer_ctrl

// ---- usb_endpoint_buffer_manager.v ----
// Purpose: endpoint buffer manager between usb protocol core and cpu
// Assumes: protocol core runs on clk_sys; usb_full_speed is asynchronous
// Notes:   two endpoints, 64 bytes each per page, wishbone data in low byte
//
// Functional notes
// R1: two 128-byte pages, cpu and usb ports
// R2: endpoint 0 is control, default length 8
// R3: control packet limit configurable up to 64
// R4: isochronous only at full speed, one direction
// R5: interrupt endpoints are IN only, 64 max
// R6: bulk only at full speed, one direction
// R7: single or dual buffer, random or sequential
// R8: single mode shares selectable page 0 or 1
// R9: dual mode swaps pages automatically
// R10: done bit marks buffer ready
// R11: offset register then data register access
// R12: increment enable advances offset per access
// R13: length accesses mean buffer empty or full
// R14: cpu writes only to device-to-host buffers
// R15: good usb packet sets flag, copies length
// R16: last cpu read raises cpu complete flag
// R17: offset reaching max length raises complete flag
// R18: frame start completes buffer when enabled
// R19: reset leaves buffers empty, offset zero
//
// Our own choices: the Wishbone register port and the register offsets.
`include "usb_epbuf_defs.vh"
`timescale 1ns/1ps
module usb_endpoint_buffer_manager (
	input  wire        clk_sys,        // 20 MHz system clock
	input  wire        reset_n,        // sync reset, active low
	input  wire        wb_cyc_i,       // wishbone cycle
	input  wire        wb_stb_i,       // wishbone strobe
	input  wire        wb_we_i,        // wishbone write
	input  wire [3:0]  wb_sel_i,       // byte lanes, lane 0 used
	input  wire [7:0]  wb_adr_i,       // byte address
	input  wire [31:0] wb_dat_i,       // write data
	output reg  [31:0] wb_dat_o,       // read data
	output reg         wb_ack_o,       // acknowledge
	output reg         irq_o,          // level interrupt
	input  wire        usb_full_speed, // async speed strap
	input  wire        usb_sof,        // start of frame pulse
	input  wire        usb_ep,         // endpoint of usb access
	input  wire        usb_wr_stb,     // usb writes one byte
	input  wire [7:0]  usb_wr_data,    // byte from usb
	input  wire        usb_rd_stb,     // usb reads one byte
	input  wire        usb_end_ok,     // packet ended correctly
	input  wire        usb_end_bad,    // packet aborted
	output reg  [7:0]  usb_rd_data,    // byte to usb
	output reg  [1:0]  usb_ep_ready,   // per endpoint ready
	output reg  [6:0]  usb_tx_len      // length for usb_ep IN buffer
);
	reg        fs_meta_r;
	reg        fs_r;
	reg        sel_r;
	reg  [7:0] cfg_r [0:1];
	reg  [6:0] maxl_r [0:1];
	reg  [3:0] stat_r;
	reg  [3:0] ien_r;
	reg  [3:0] stat_nxt;
	reg  [31:0] rd_val;

	wire        req    = wb_cyc_i & wb_stb_i & !wb_ack_o;
	wire        wr0    = req & wb_we_i & wb_sel_i[0];
	wire        rd     = req & !wb_we_i;
	wire [7:0]  wdat   = wb_dat_i[7:0];

	wire [13:0] coff;
	wire [13:0] ucnt;
	wire [13:0] clen;
	wire [13:0] ulen;
	wire [1:0]  cbf;
	wire [1:0]  ubf;
	wire [1:0]  cpage;
	wire [1:0]  upage;
	wire [1:0]  uready;
	wire [1:0]  cavail;
	wire [1:0]  usb_cmpl;
	wire [1:0]  cpu_cmpl;
	wire [1:0]  ep_ok;
	wire [1:0]  dir_eff;
	wire [1:0]  cpu_wr;

	wire [7:0]  ram_a_rdata;
	wire [7:0]  ram_b_rdata;
	wire [6:0]  coff_s = sel_r ? coff[13:7] : coff[6:0];
	wire [6:0]  clen_s = sel_r ? clen[13:7] : clen[6:0];
	wire [6:0]  ucnt_u = usb_ep ? ucnt[13:7] : ucnt[6:0];
	wire [6:0]  ulen_u = usb_ep ? ulen[13:7] : ulen[6:0];
	wire        usb_ok_u = usb_ep ? (ep_ok[1] & uready[1]) : uready[0];
	wire        usb_in_u = dir_eff[usb_ep];

	// single ram: address {page, endpoint, byte}; 64 bytes per endpoint per page
	usb_packet_ram u_ram (
		.clk_sys (clk_sys),
		.a_we    (|cpu_wr),
		.a_addr  ({cpage[sel_r], sel_r, coff_s[5:0]}),
		.a_wdata (wdat),
		.a_rdata (ram_a_rdata),
		.b_we    (usb_wr_stb & !usb_in_u & usb_ok_u),
		.b_addr  ({upage[usb_ep], usb_ep, ucnt_u[5:0]}),
		.b_wdata (usb_wr_data),
		.b_rdata (ram_b_rdata)
	); // R1

	genvar i;
	generate
		for (i = 0; i < 2; i = i + 1) begin : g_ep
			wire [1:0] ep_type = (i == 0) ? `T_CTRL : cfg_r[i][`CF_TYPE_HI:`CF_TYPE_LO]; // R2
			wire       here_u  = (usb_ep == i) & ep_ok[i];
			wire       here_c  = (sel_r == i);

			// iso and bulk need full speed; interrupt pipes are forced IN
			assign ep_ok[i]   = fs_r | ((ep_type != `T_ISO) && (ep_type != `T_BULK)); // R4 R6
			assign dir_eff[i] = cfg_r[i][`CF_DIR] | (ep_type == `T_INT); // R5
			// writes to a host-to-device buffer are dropped without error
			assign cpu_wr[i]  = here_c & wr0 & (wb_adr_i == `A_BUF_DATA) &
				dir_eff[i] & cavail[i]; // R14

			ep_buffer_ctrl u_ep (
				.clk_sys   (clk_sys),
				.reset_n   (reset_n),
				.dual_en   (cfg_r[i][`CF_DUAL]), // R7
				.page_sel  (cfg_r[i][`CF_PAGE]),
				.dir_in    (dir_eff[i]),
				.inc_en    (cfg_r[i][`CF_INC]), // R7
				.sof_cmpl_en (cfg_r[i][`CF_SOF_CMPL]),
				.max_len   (maxl_r[i]),
				.off_wr    (here_c & wr0 & (wb_adr_i == `A_BUF_OFF)), // R11
				.off_wdata (wdat[6:0]),
				.cpu_rd    (here_c & rd & (wb_adr_i == `A_BUF_DATA)),
				.cpu_wr    (cpu_wr[i]),
				.cpu_done  (here_c & wr0 & (wb_adr_i == `A_EP_CTRL) & wdat[`CF_DONE]), // R10
				.usb_byte  (here_u & (dir_eff[i] ? usb_rd_stb : usb_wr_stb)),
				.usb_ok    (here_u & usb_end_ok),
				.usb_bad   (here_u & usb_end_bad),
				.sof       (usb_sof), // R18
				.coff_r    (coff[i*7 +: 7]),
				.ucnt_r    (ucnt[i*7 +: 7]),
				.clen_r    (clen[i*7 +: 7]),
				.ulen_r    (ulen[i*7 +: 7]),
				.cbf_r     (cbf[i]),
				.ubf_r     (ubf[i]),
				.cpu_page  (cpage[i]),
				.usb_page  (upage[i]),
				.usb_ready (uready[i]),
				.cpu_avail (cavail[i]),
				.usb_cmpl  (usb_cmpl[i]),
				.cpu_cmpl  (cpu_cmpl[i])
			);
		end
	endgenerate

	// register read mux
	always @* begin
		rd_val = 32'h00000000;
		if (wb_adr_i == `A_EP_SEL)
			rd_val = {31'h00000000, sel_r};
		else if (wb_adr_i == `A_EP_CTRL)
			rd_val = {21'h000000, ep_ok[sel_r], ubf[sel_r], cbf[sel_r], cfg_r[sel_r]};
		else if (wb_adr_i == `A_BUF_OFF)
			rd_val = {25'h0000000, coff_s};
		else if (wb_adr_i == `A_BUF_DATA)
			rd_val = {24'h000000, ram_a_rdata}; // R11
		else if (wb_adr_i == `A_EP_LEN)
			rd_val = {25'h0000000, clen_s}; // R15
		else if (wb_adr_i == `A_MAX_LEN)
			rd_val = {25'h0000000, maxl_r[sel_r]};
		else if (wb_adr_i == `A_IRQ_STAT)
			rd_val = {28'h0000000, stat_r};
		else if (wb_adr_i == `A_IRQ_EN)
			rd_val = {28'h0000000, ien_r};
	end

	// status: set wins over a clear in the same cycle
	always @* begin
		stat_nxt = stat_r;
		if (wr0 && (wb_adr_i == `A_IRQ_CLR))
			stat_nxt = stat_nxt & ~wdat[3:0];
		stat_nxt = stat_nxt | {cpu_cmpl[1], usb_cmpl[1], cpu_cmpl[0], usb_cmpl[0]}; // R15 R16 R17
	end

	always @(posedge clk_sys) begin
		if (!reset_n) begin
			fs_meta_r    <= 1'b0;
			fs_r         <= 1'b0;
			wb_ack_o     <= 1'b0;
			wb_dat_o     <= 32'h00000000;
			irq_o        <= 1'b0;
			sel_r        <= 1'b0;
			cfg_r[0]     <= `CFG_RESET; // R19
			cfg_r[1]     <= `CFG_RESET;
			maxl_r[0]    <= `CTRL_DEF_LEN; // R2
			maxl_r[1]    <= `EP1_DEF_LEN;
			stat_r       <= 4'h0;
			ien_r        <= 4'h0;
			usb_rd_data  <= 8'h00;
			usb_ep_ready <= 2'h0;
			usb_tx_len   <= 7'h00;
		end else begin
			fs_meta_r <= usb_full_speed;
			fs_r      <= fs_meta_r;
			wb_ack_o  <= req;
			wb_dat_o  <= rd ? rd_val : 32'h00000000;
			stat_r    <= stat_nxt;
			irq_o     <= |(stat_nxt & ien_r);
			if (wr0) begin
				if (wb_adr_i == `A_EP_SEL)
					sel_r <= wdat[0];
				else if (wb_adr_i == `A_EP_CTRL)
					cfg_r[sel_r] <= wdat & ~(8'h01 << `CF_DONE);
				else if (wb_adr_i == `A_MAX_LEN)
					// a larger value is clipped to the 64-byte packet limit
					maxl_r[sel_r] <= (wdat[6:0] > `PKT_MAX_LEN) ?
						`PKT_MAX_LEN : wdat[6:0]; // R3 R4 R5 R6
				else if (wb_adr_i == `A_IRQ_EN)
					ien_r <= wdat[3:0];
			end
			// byte is captured at the strobe, so usb sees it one cycle later
			if (usb_rd_stb & usb_in_u & usb_ok_u)
				usb_rd_data <= ram_b_rdata;
			usb_ep_ready <= uready & ep_ok;
			usb_tx_len   <= ulen_u;
		end
	end
endmodule // usb_endpoint_buffer_manager

// ---- usb_epbuf_props.sv ----
// Purpose: port checks for the endpoint buffer manager
// Assumes: bound to the top module, one clock domain
// Notes:   only relations visible at the ports are checked here
`timescale 1ns/1ps
module usb_epbuf_props (
	input wire        clk_sys,     // system clock
	input wire        reset_n,     // sync reset, active low
	input wire        wb_cyc_i,    // cycle
	input wire        wb_stb_i,    // strobe
	input wire        wb_we_i,     // write
	input wire [3:0]  wb_sel_i,    // byte lanes
	input wire [7:0]  wb_adr_i,    // byte address
	input wire [31:0] wb_dat_i,    // write data
	input wire [31:0] wb_dat_o,    // read data
	input wire        wb_ack_o,    // acknowledge
	input wire        irq_o,       // level interrupt
	input wire        usb_rd_stb,  // usb read strobe
	input wire [7:0]  usb_rd_data, // byte to usb
	input wire [6:0]  usb_tx_len   // in length
);
	// write-only clear reads back as zero, like a hole in the map
	wire unmap_rd = !wb_we_i && (wb_adr_i > 8'h20 || wb_adr_i[1:0] != 2'h0 || wb_adr_i == 8'h1c);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence wb_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence irq_off_wr;
		wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h20 && wb_dat_i[3:0] == 4'h0;
	endsequence
	ack_after_req_a: assert property (wb_take |=> wb_ack_o)
		else $error("no ack one cycle after request");
	ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_has_req_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data not zero outside ack");
	unmapped_read_zero_a: assert property (wb_ack_o && $past(unmap_rd) |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	max_len_clip_a: assert property (
		wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h14) |-> wb_dat_o <= 32'h40)
		else $error("max length above 64");
	tx_len_bound_a: assert property (usb_tx_len <= 7'h40)
		else $error("usb length above 64");
	irq_mask_off_a: assert property (wb_take ##0 irq_off_wr |-> ##2 !irq_o)
		else $error("irq high with all enables off");
	rd_data_hold_a: assert property (!$past(usb_rd_stb) |-> $stable(usb_rd_data))
		else $error("usb byte changed without read");
endmodule // usb_epbuf_props

bind usb_endpoint_buffer_manager usb_epbuf_props u_props (.clk_sys(clk_sys), .reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_o(irq_o), .usb_rd_stb(usb_rd_stb), .usb_rd_data(usb_rd_data), .usb_tx_len(usb_tx_len));

// ---- usb_host_model.sv ----
// Purpose: usb host stand-in driving the protocol core strobes
// Assumes: all strobes are one-cycle pulses on clk_sys
// Notes:   with gap above 0, idle data carries the inverse byte, never the last one
`timescale 1ns/1ps
module usb_host_model (
	input wire       clk_sys,          // system clock
	output reg       usb_sof = 1'h0,     // frame start
	output reg       usb_ep = 1'h0,      // endpoint addressed
	output reg       usb_wr_stb = 1'h0,  // byte to device
	output reg [7:0] usb_wr_data = 8'h5a, // byte value
	output reg       usb_rd_stb = 1'h0,  // byte from device
	output reg       usb_end_ok = 1'h0   // packet ended well
);
	// gap 0 streams bytes back to back, larger gaps model a slow host
	task send_out(input reg ep, input int n, input [7:0] base, input int gap);
		int i;
		begin
			@(posedge clk_sys);
			usb_ep <= ep;
			for (i = 0; i < n; i++) begin
				usb_wr_stb <= 1'h1;
				usb_wr_data <= base + i[7:0];
				@(posedge clk_sys);
				if (gap > 0) begin
					usb_wr_stb <= 1'h0;
					usb_wr_data <= ~usb_wr_data;
					repeat (gap) @(posedge clk_sys);
				end
			end
			usb_wr_stb <= 1'h0;
			usb_end_ok <= 1'h1;
			@(posedge clk_sys);
			usb_end_ok <= 1'h0;
		end
	endtask
	task fetch(input reg ep);
		begin
			@(posedge clk_sys);
			usb_ep <= ep;
			@(posedge clk_sys);
			usb_rd_stb <= 1'h1;
			@(posedge clk_sys);
			usb_rd_stb <= 1'h0;
		end
	endtask
	task finish;
		begin
			@(posedge clk_sys);
			usb_end_ok <= 1'h1;
			@(posedge clk_sys);
			usb_end_ok <= 1'h0;
		end
	endtask
	task frame;
		begin
			@(posedge clk_sys);
			usb_sof <= 1'h1;
			@(posedge clk_sys);
			usb_sof <= 1'h0;
		end
	endtask
endmodule // usb_host_model

// ---- tb_usb_endpoint_buffer_manager.sv ----
// Purpose: self-checking bench for the endpoint buffer manager
// Assumes: host model drives the usb strobes, bench drives wishbone
// Notes:   ep1 runs single mode on both pages, then dual mode back to back
`timescale 1ns/1ps
`include "usb_epbuf_defs.vh"
module tb_usb_endpoint_buffer_manager;
	reg         clk_sys = 1'h0, reset_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
	reg  [3:0]  wb_sel_i = 4'h0;
	reg  [7:0]  wb_adr_i = 8'h00;
	reg  [31:0] wb_dat_i = 32'h0, q;
	reg         usb_full_speed = 1'h0, usb_end_bad = 1'h0;
	wire [31:0] wb_dat_o;
	wire        wb_ack_o, irq_o, usb_sof, usb_ep, usb_wr_stb, usb_rd_stb, usb_end_ok;
	wire [7:0]  usb_wr_data, usb_rd_data;
	wire [1:0]  usb_ep_ready;
	wire [6:0]  usb_tx_len;
	int         n_errors = 0, checks_done = 0, i;
	always #25 clk_sys = ~clk_sys;
	usb_endpoint_buffer_manager uut (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
		.usb_full_speed(usb_full_speed), .usb_sof(usb_sof), .usb_ep(usb_ep),
		.usb_wr_stb(usb_wr_stb), .usb_wr_data(usb_wr_data), .usb_rd_stb(usb_rd_stb),
		.usb_end_ok(usb_end_ok), .usb_end_bad(usb_end_bad), .usb_rd_data(usb_rd_data),
		.usb_ep_ready(usb_ep_ready), .usb_tx_len(usb_tx_len));
	usb_host_model host (.clk_sys(clk_sys), .usb_sof(usb_sof), .usb_ep(usb_ep),
		.usb_wr_stb(usb_wr_stb), .usb_wr_data(usb_wr_data), .usb_rd_stb(usb_rd_stb),
		.usb_end_ok(usb_end_ok));
	task complete_run;
		begin
			$display("checks %0d errors %0d", checks_done, n_errors);
			if (n_errors == 0 && checks_done > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task chk(input string what, input [31:0] exp, input [31:0] got);
		begin
			checks_done++;
			if (got !== exp) begin
				n_errors++;
				$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	// entered just after an edge; result lands in q
	task wb(input reg we, input [7:0] adr, input [7:0] d, input [3:0] sel);
		int t;
		begin
			t = 0;
			wb_cyc_i <= 1'h1;
			wb_stb_i <= 1'h1;
			wb_we_i <= we;
			wb_sel_i <= sel;
			wb_adr_i <= adr;
			wb_dat_i <= {24'h0, d};
			do begin
				@(posedge clk_sys);
				t++;
			end while (wb_ack_o !== 1'h1 && t < 20);
			chk("ack seen", 1, wb_ack_o);
			q = wb_dat_o;
			wb_cyc_i <= 1'h0;
			wb_stb_i <= 1'h0;
			@(posedge clk_sys);
		end
	endtask
	task rd(input [7:0] adr);
		wb(1'h0, adr, 8'h00, 4'hf);
	endtask
	task wr(input [7:0] adr, input [7:0] d);
		wb(1'h1, adr, d, 4'hf);
	endtask
	task load_in(input int n, input [7:0] b);
		begin
			wr(`A_BUF_OFF, 8'h00);
			for (i = 0; i < n; i++)
				wr(`A_BUF_DATA, b + i[7:0]);
		end
	endtask
	// left: whether the other page is still waiting for usb after this packet
	task drain_in(input int n, input [7:0] b, input reg left);
		int t;
		begin
			t = 0;
			while (usb_ep_ready[1] !== 1'h1 && t < 20) begin
				@(posedge clk_sys);
				t++;
			end
			chk("ep1 ready", 1, usb_ep_ready[1]);
			for (i = 0; i < n; i++) begin
				host.fetch(1'h1);
				@(negedge clk_sys);
				chk("usb byte", b + i[7:0], usb_rd_data);
			end
			chk("tx length", n, usb_tx_len);
			host.finish;
			repeat (3) @(posedge clk_sys);
			chk("ep1 ready after", left, usb_ep_ready[1]);
		end
	endtask
	task t_reset;
		begin
			rd(`A_MAX_LEN);
			chk("ep0 max", 8, q);
			rd(`A_BUF_OFF);
			chk("offset", 0, q);
			rd(`A_EP_CTRL);
			chk("buffers empty", 0, q[9:8]);
			rd(8'h24);
			chk("unmapped", 0, q);
			wr(`A_MAX_LEN, 8'h7f);
			wb(1'h1, `A_MAX_LEN, 8'h10, 4'h0);
			rd(`A_MAX_LEN);
			chk("ctrl max clip", 8'h40, q);
			wr(`A_MAX_LEN, 8'h08);
		end
	endtask
	task t_out_ep0;
		begin
			wr(`A_IRQ_EN, 8'h0f);
			host.send_out(1'h0, 5, 8'h30, 1);
			repeat (2) @(posedge clk_sys);
			rd(`A_IRQ_STAT);
			chk("usb done ep0", 1, q[0]);
			chk("irq up", 1, irq_o);
			rd(`A_EP_LEN);
			chk("out length", 5, q);
			wr(`A_EP_CTRL, 8'h08);
			wr(`A_BUF_OFF, 8'h00);
			wr(`A_BUF_DATA, 8'hee);
			wr(`A_BUF_OFF, 8'h00);
			for (i = 0; i < 5; i++) begin
				rd(`A_BUF_DATA);
				chk("out byte", 8'h30 + i, q);
			end
			rd(`A_IRQ_STAT);
			chk("cpu done ep0", 2'h3, q[1:0]);
			wr(`A_IRQ_CLR, 8'h03);
			rd(`A_IRQ_STAT);
			chk("status cleared", 0, q);
			chk("irq down", 0, irq_o);
		end
	endtask
	task t_in_max;
		begin
			wr(`A_EP_SEL, 8'h01);
			for (i = 0; i < 4; i++) begin
				wr(`A_EP_CTRL, {i[1:0], 6'h0c});
				rd(`A_EP_CTRL);
				chk("type field", i, q[7:6]);
			end
			wr(`A_EP_CTRL, 8'h8c);
			rd(`A_EP_CTRL);
			chk("bulk slow off", 0, q[10]);
			usb_full_speed <= 1'h1;
			repeat (4) @(posedge clk_sys);
			rd(`A_EP_CTRL);
			chk("bulk usable", 1, q[10]);
			wr(`A_MAX_LEN, 8'h04);
			wr(`A_IRQ_CLR, 8'h0f);
			load_in(4, 8'ha0);
			rd(`A_IRQ_STAT);
			chk("cpu done on max", 1, q[3]);
			drain_in(4, 8'ha0, 1'h0);
			rd(`A_IRQ_STAT);
			chk("usb done ep1", 1, q[2]);
		end
	endtask
	task t_in_done;
		begin
			load_in(2, 8'h60);
			wr(`A_EP_CTRL, 8'hac);
			drain_in(2, 8'h60, 1'h0);
		end
	endtask
	task t_in_sof;
		begin
			wr(`A_EP_CTRL, 8'h9e);
			load_in(3, 8'h70);
			host.frame;
			drain_in(3, 8'h70, 1'h0);
			wr(`A_IRQ_EN, 8'h00);
			chk("irq masked", 0, irq_o);
		end
	endtask
	// second packet is loaded while usb still owns the first one
	task t_in_dual;
		begin
			wr(`A_EP_CTRL, 8'h8d);
			load_in(4, 8'hb0);
			load_in(4, 8'hc0);
			rd(`A_EP_CTRL);
			chk("both full", 2'h3, q[9:8]);
			drain_in(4, 8'hb0, 1'h1);
			drain_in(4, 8'hc0, 1'h0);
		end
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(posedge clk_sys);
		t_reset;
		t_out_ep0;
		t_in_max;
		t_in_done;
		t_in_sof;
		t_in_dual;
		complete_run;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		n_errors++;
		complete_run;
	end
endmodule // tb_usb_endpoint_buffer_manager
